/* include/iobd_pkg.sv */
// Constants, select layout and enumerations for the I/O bus decode block.
// Assumes one system clock; every I/O side pin is asynchronous to it.
//
// Summary of operation
// - Addresses 0x03000000 to 0x03FFFFFF form main I/O space, decoded into regions.
// - Addresses 0x08000000 to 0x0FFFFFFF form extended space; extended-area select asserts there.
// - Module select asserts for regions at 0x03000000 and 0x03030000.
// - Combo select at 0x03010000; combo DMA acknowledge at 0x03012000.
// - Region at 0x0302A000 asserts combo DMA acknowledge and terminal count together.
// - Card select two at 0x0302B000; card select one at 0x0302B800 to 0x0302C000.
// - Simple region at 0x03210000 asserts simple selects; second qualified by extra-decode.
// - Extra-decode high: module select only in the two 16 Kbyte windows.
// - Extra-decode high: extended select only in first 16 Mbyte area.
// - Extra-decode high: second simple select only in four 16 Kbyte windows.
// - Extra-decode low: module and extended selects cover their whole spaces.
// - Extra-decode low: second simple select in four 64 Kbyte windows.
// - Simple accesses are 16-bit; address bits 20 and 19 pick the speed.
// - Writes drive upper data halfword out; reads return bus on lower halfword.
// - Ready input has no effect on simple cycles.
// - Simple accesses assert first simple select with read or write strobe, 8 MHz timed.
// - Simple cycle lengths in 8 MHz periods: 7, 6, 5, 5.
// - Sync cycles align to 2 MHz output, up to three extra periods.
// - Module cycles run with request out and grant in for both module ranges.
// - Module cycles assert module select and direction, no strobes, ignore ready.
// - Module cycle ends at reference rising edge with request and grant both low.
package iobd_pkg;

  typedef enum logic [1:0] {IOBD_KIND_NONE, IOBD_KIND_SIMPLE, IOBD_KIND_MODULE, IOBD_KIND_PC} iobd_kind_t;

  ////////////////////////////////////////////////////////////////////////////
  // Address map
  localparam logic [7:0] IOBD_MAIN_TOP = 8'h03;
  localparam logic [4:0] IOBD_EXT_TOP = 5'h01;
  localparam logic [7:0] IOBD_EXT_FIRST = 8'h08;
  localparam logic [7:0] IOBD_MOD_BLK_LO = 8'h00;
  localparam logic [7:0] IOBD_MOD_BLK_HI = 8'h03;
  localparam logic [31:0] IOBD_COMBO_BASE = 32'h0301_0000;
  localparam logic [31:0] IOBD_DACK_BASE = 32'h0301_2000;
  localparam logic [31:0] IOBD_DACK_TC_BASE = 32'h0302_a000;
  localparam logic [31:0] IOBD_CARD2_BASE = 32'h0302_b000;
  localparam logic [31:0] IOBD_CARD1_BASE = 32'h0302_b800;
  localparam logic [31:0] IOBD_RSVD_BASE = 32'h0302_c000;
  localparam logic [31:0] IOBD_SIO_BASE = 32'h0321_0000;
  localparam logic [31:0] IOBD_SIO_END = 32'h0340_0000;
  localparam logic [2:0] IOBD_SIO2_HI = 3'h1;
  localparam logic [2:0] IOBD_SIO2_LO = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Select vector: bit positions and idle levels (terminal count idles low)
  localparam int IOBD_SEL_W = 9;
  localparam int IOBD_SEL_EXT = 0;
  localparam int IOBD_SEL_MOD = 1;
  localparam int IOBD_SEL_COMBO = 2;
  localparam int IOBD_SEL_DACK = 3;
  localparam int IOBD_SEL_TC = 4;
  localparam int IOBD_SEL_CARD1 = 5;
  localparam int IOBD_SEL_CARD2 = 6;
  localparam int IOBD_SEL_SIO1 = 7;
  localparam int IOBD_SEL_SIO2 = 8;
  localparam logic [8:0] IOBD_SEL_IDLE = 9'h1ef;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pin positions and reset levels
  localparam int IOBD_SY_W = 5;
  localparam int IOBD_SY_EIGHT_MHZ_IO_CLOCK = 0;
  localparam int IOBD_SY_REF8 = 1;
  localparam int IOBD_SY_GRANT = 2;
  localparam int IOBD_SY_LATCH = 3;
  localparam int IOBD_SY_EXTRA = 4;
  localparam logic [4:0] IOBD_SY_RESET = 5'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts in 8 MHz periods
  localparam logic [1:0] IOBD_SPEED_SLOW = 2'h0;
  localparam logic [1:0] IOBD_SPEED_MEDIUM = 2'h1;
  localparam logic [1:0] IOBD_SPEED_FAST = 2'h2;
  localparam logic [1:0] IOBD_SPEED_SYNC = 2'h3;
  localparam logic [3:0] IOBD_LEN_SLOW = 4'h7;
  localparam logic [3:0] IOBD_LEN_MEDIUM = 4'h6;
  localparam logic [3:0] IOBD_LEN_FAST = 4'h5;
  localparam logic [3:0] IOBD_LEN_SYNC = 4'h5;
  localparam logic [1:0] IOBD_SYNC_START = 2'h2;
  localparam int IOBD_PC_HOLD_DEFAULT = 4;

endpackage

/* include/iobd_dec_if.sv */
// Carrier between the cycle engine and the address decoder.
// Assumes the engine drives address and extra-decode level in its own clock.
interface iobd_dec_if;
  logic [31:0] addr;
  logic extra;
  logic [8:0] sel;
  iobd_pkg::iobd_kind_t kind;

  modport decoder (
    input addr,
    input extra,
    output sel,
    output kind
  );

  modport engine (
    output addr,
    output extra,
    input sel,
    input kind
  );
endinterface

/* hdl/iobd_decode.sv */
// Combinational address decoder: chip select vector and cycle kind.
// Assumes address is stable while sampled; no clock inside.
module iobd_decode (
  iobd_dec_if.decoder dec
);

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire [31:0] a = dec.addr;
  wire in_main = a[31:24] == iobd_pkg::IOBD_MAIN_TOP;
  wire in_ext = a[31:27] == iobd_pkg::IOBD_EXT_TOP;
  wire ext_first = a[31:24] == iobd_pkg::IOBD_EXT_FIRST;
  wire mod_range = in_main && (a[23:16] == iobd_pkg::IOBD_MOD_BLK_LO || a[23:16] == iobd_pkg::IOBD_MOD_BLK_HI);
  wire narrow = a[15:14] == 2'h0;
  wire mod_sel = dec.extra ? (mod_range && narrow) : mod_range;
  wire ext_sel = dec.extra ? ext_first : in_ext;
  wire combo = in_range(a, iobd_pkg::IOBD_COMBO_BASE, iobd_pkg::IOBD_DACK_BASE);
  wire dack = in_range(a, iobd_pkg::IOBD_DACK_BASE, iobd_pkg::IOBD_DACK_TC_BASE);
  wire dack_tc = in_range(a, iobd_pkg::IOBD_DACK_TC_BASE, iobd_pkg::IOBD_CARD2_BASE);
  wire card2 = in_range(a, iobd_pkg::IOBD_CARD2_BASE, iobd_pkg::IOBD_CARD1_BASE);
  wire card1 = in_range(a, iobd_pkg::IOBD_CARD1_BASE, iobd_pkg::IOBD_RSVD_BASE);
  wire simple = in_range(a, iobd_pkg::IOBD_SIO_BASE, iobd_pkg::IOBD_SIO_END);
  wire sio2_win = a[23:21] == iobd_pkg::IOBD_SIO2_HI && a[18:16] == iobd_pkg::IOBD_SIO2_LO;
  wire sio2 = simple && sio2_win && (!dec.extra || narrow);
  wire pc_any = combo || dack || dack_tc || card1 || card2 || ext_sel;

  // Anything else, reserved or internal, leaves every select idle
  assign dec.sel = {sio2, simple, card2, card1, dack_tc, dack || dack_tc, combo, mod_sel, ext_sel};
  assign dec.kind = mod_sel ? iobd_pkg::IOBD_KIND_MODULE :
                    simple ? iobd_pkg::IOBD_KIND_SIMPLE :
                    pc_any ? iobd_pkg::IOBD_KIND_PC : iobd_pkg::IOBD_KIND_NONE;

endmodule // iobd_decode

/* hdl/iobd_top.sv */
// I/O bus cycle engine: decode, simple fixed-timing cycles, module handshake cycles.
// Assumes a one-request-at-a-time master on clk_sys; all bus pins are asynchronous.
module iobd_top #(
  parameter int PC_HOLD = iobd_pkg::IOBD_PC_HOLD_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [31:0] req_wdata,
  output logic req_done,
  output logic [31:0] req_rdata,
  input wire logic [15:0] io_data_bus_in,
  output logic [15:0] io_data_bus_out,
  output logic io_data_bus_oe,
  output logic extended_area_select_n,
  output logic module_space_select_n,
  output logic combo_chip_select_n,
  output logic combo_dma_ack_n,
  output logic terminal_count_out,
  output logic card_select_one_n,
  output logic card_select_two_n,
  output logic simple_io_select_one_n,
  output logic simple_io_select_two_n,
  input wire logic extra_decode_select,
  input wire logic eight_mhz_io_clock,
  input wire logic eight_mhz_reference,
  output logic two_mhz_clock_out,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic module_request_n,
  input wire logic module_grant_n,
  output logic io_read_not_write,
  input wire logic module_latch_strobe_n
);

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} iobd_state_t;

  function automatic logic [3:0] sio_len(input logic [1:0] speed);
    case (speed)
      iobd_pkg::IOBD_SPEED_SLOW: sio_len = iobd_pkg::IOBD_LEN_SLOW;
      iobd_pkg::IOBD_SPEED_MEDIUM: sio_len = iobd_pkg::IOBD_LEN_MEDIUM;
      iobd_pkg::IOBD_SPEED_FAST: sio_len = iobd_pkg::IOBD_LEN_FAST;
      default: sio_len = iobd_pkg::IOBD_LEN_SYNC;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two and three agree
  logic [4:0] sy1;
  logic [4:0] sy2;
  logic [4:0] sy3;
  logic [4:0] lvl;
  logic [15:0] bus1;
  logic [15:0] bus2;
  logic [15:0] bus3;

  wire [4:0] pins = {extra_decode_select, module_latch_strobe_n, module_grant_n, eight_mhz_reference,
                     eight_mhz_io_clock};
  wire [4:0] next_lvl = (sy2 & sy3) | (lvl & (sy2 | sy3));
  wire [4:0] rise = ~lvl & sy2 & sy3;
  wire [4:0] fall = lvl & ~sy2 & ~sy3;
  wire eight_mhz_io_clock_rise = rise[iobd_pkg::IOBD_SY_EIGHT_MHZ_IO_CLOCK];
  wire ref_rise = rise[iobd_pkg::IOBD_SY_REF8];
  wire latch_fall = fall[iobd_pkg::IOBD_SY_LATCH];
  wire grant_low = !lvl[iobd_pkg::IOBD_SY_GRANT];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sy1 <= iobd_pkg::IOBD_SY_RESET;
      sy2 <= iobd_pkg::IOBD_SY_RESET;
      sy3 <= iobd_pkg::IOBD_SY_RESET;
      lvl <= iobd_pkg::IOBD_SY_RESET;
    end else begin
      sy1 <= pins;
      sy2 <= sy1;
      sy3 <= sy2;
      lvl <= next_lvl;
    end
  end

  // Bus data only needs to be stable at the capture point, so no agreement filter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus1 <= 16'h0000;
      bus2 <= 16'h0000;
      bus3 <= 16'h0000;
    end else begin
      bus1 <= io_data_bus_in;
      bus2 <= bus1;
      bus3 <= bus2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 2 MHz output: divide the synchronised 8 MHz clock by four
  logic [1:0] div;
  wire [1:0] next_div = div + 2'h1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div <= 2'h0;
      two_mhz_clock_out <= 1'b0;
    end else if (eight_mhz_io_clock_rise) begin
      div <= next_div;
      two_mhz_clock_out <= next_div[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoder
  iobd_dec_if u_if ();

  iobd_decode u_dec (
    .dec(u_if.decoder)
  );

  assign u_if.addr = req_addr;
  assign u_if.extra = lvl[iobd_pkg::IOBD_SY_EXTRA];

  ////////////////////////////////////////////////////////////////////////////
  // Cycle engine
  iobd_state_t state;
  iobd_state_t next_state;
  iobd_pkg::iobd_kind_t kind_q;
  iobd_pkg::iobd_kind_t next_kind;
  logic [8:0] sel_q;
  logic [8:0] next_sel_q;
  logic [8:0] sel_out;
  logic [8:0] next_sel_out;
  logic write_q;
  logic next_write;
  logic [15:0] wdata_q;
  logic [15:0] next_wdata;
  logic [1:0] speed_q;
  logic [1:0] next_speed;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_done;
  logic [31:0] next_rdata;
  logic [15:0] next_dout;
  logic next_oe;
  logic next_rd_n;
  logic next_wr_n;
  logic next_req_n;
  logic next_rnw;

  wire is_sync = kind_q == iobd_pkg::IOBD_KIND_SIMPLE && speed_q == iobd_pkg::IOBD_SPEED_SYNC;
  wire start_ok = !is_sync || next_div == iobd_pkg::IOBD_SYNC_START;
  wire [3:0] pc_len = 4'(PC_HOLD);

  always_comb begin
    logic finish;
    finish = 1'b0;
    next_state = state;
    next_kind = kind_q;
    next_sel_q = sel_q;
    next_sel_out = sel_out;
    next_write = write_q;
    next_wdata = wdata_q;
    next_speed = speed_q;
    next_cnt = cnt;
    next_done = 1'b0;
    next_rdata = req_rdata;
    next_dout = io_data_bus_out;
    next_oe = io_data_bus_oe;
    next_rd_n = io_read_strobe_n;
    next_wr_n = io_write_strobe_n;
    next_req_n = module_request_n;
    next_rnw = io_read_not_write;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_kind = u_if.kind;
          next_sel_q = u_if.sel;
          next_write = req_write;
          next_wdata = req_wdata[31:16];
          next_speed = req_addr[20:19];
          next_rdata = 32'h0000_0000;
          if (u_if.kind == iobd_pkg::IOBD_KIND_NONE) begin
            next_done = 1'b1;
          end else begin
            next_state = ST_ARM;
          end
        end
      end
      ST_ARM: begin
        // Start on an 8 MHz edge; sync cycles may wait up to three more
        if (eight_mhz_io_clock_rise && start_ok) begin
          next_sel_out = iobd_pkg::IOBD_SEL_IDLE ^ sel_q;
          next_cnt = 4'h1;
          next_rnw = !write_q;
          next_oe = write_q;
          next_dout = wdata_q;
          if (kind_q == iobd_pkg::IOBD_KIND_MODULE) begin
            next_req_n = 1'b0;
          end else begin
            next_rd_n = write_q;
            next_wr_n = !write_q;
          end
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        case (kind_q)
          iobd_pkg::IOBD_KIND_SIMPLE: begin
            // Length fixed by speed code alone, no ready input at all
            if (eight_mhz_io_clock_rise) begin
              next_cnt = cnt + 4'h1;
              finish = cnt == sio_len(speed_q);
            end
          end
          iobd_pkg::IOBD_KIND_MODULE: begin
            if (latch_fall && !write_q) begin
              next_rdata = {16'h0000, bus3};
            end
            finish = ref_rise && !module_request_n && grant_low;
          end
          default: begin
            if (eight_mhz_io_clock_rise) begin
              next_cnt = cnt + 4'h1;
              finish = cnt == pc_len;
            end
          end
        endcase
      end
      default: next_state = ST_IDLE;
    endcase
    if (finish) begin
      if (!write_q && kind_q != iobd_pkg::IOBD_KIND_MODULE) begin
        next_rdata = {16'h0000, bus3};
      end
      next_sel_out = iobd_pkg::IOBD_SEL_IDLE;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_req_n = 1'b1;
      next_oe = 1'b0;
      next_rnw = 1'b1;
      next_done = 1'b1;
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      kind_q <= iobd_pkg::IOBD_KIND_NONE;
      sel_q <= 9'h000;
      write_q <= 1'b0;
      wdata_q <= 16'h0000;
      speed_q <= 2'h0;
      cnt <= 4'h0;
    end else begin
      state <= next_state;
      kind_q <= next_kind;
      sel_q <= next_sel_q;
      write_q <= next_write;
      wdata_q <= next_wdata;
      speed_q <= next_speed;
      cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_out <= iobd_pkg::IOBD_SEL_IDLE;
      req_done <= 1'b0;
      req_rdata <= 32'h0000_0000;
      io_data_bus_out <= 16'h0000;
      io_data_bus_oe <= 1'b0;
      io_read_strobe_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      module_request_n <= 1'b1;
      io_read_not_write <= 1'b1;
    end else begin
      sel_out <= next_sel_out;
      req_done <= next_done;
      req_rdata <= next_rdata;
      io_data_bus_out <= next_dout;
      io_data_bus_oe <= next_oe;
      io_read_strobe_n <= next_rd_n;
      io_write_strobe_n <= next_wr_n;
      module_request_n <= next_req_n;
      io_read_not_write <= next_rnw;
    end
  end

  assign extended_area_select_n = sel_out[iobd_pkg::IOBD_SEL_EXT];
  assign module_space_select_n = sel_out[iobd_pkg::IOBD_SEL_MOD];
  assign combo_chip_select_n = sel_out[iobd_pkg::IOBD_SEL_COMBO];
  assign combo_dma_ack_n = sel_out[iobd_pkg::IOBD_SEL_DACK];
  assign terminal_count_out = sel_out[iobd_pkg::IOBD_SEL_TC];
  assign card_select_one_n = sel_out[iobd_pkg::IOBD_SEL_CARD1];
  assign card_select_two_n = sel_out[iobd_pkg::IOBD_SEL_CARD2];
  assign simple_io_select_one_n = sel_out[iobd_pkg::IOBD_SEL_SIO1];
  assign simple_io_select_two_n = sel_out[iobd_pkg::IOBD_SEL_SIO2];

endmodule // iobd_top

/* verif/iobd_monitor.sv */
// Pin-level checks on the I/O bus decode block, bound to its top module.
// Assumes one request at a time from the master and a free-running 8 MHz clock.
module iobd_monitor #(
  parameter int PC_HOLD = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_done,
  input wire logic io_data_bus_oe,
  input wire logic module_space_select_n,
  input wire logic combo_dma_ack_n,
  input wire logic terminal_count_out,
  input wire logic simple_io_select_one_n,
  input wire logic simple_io_select_two_n,
  input wire logic eight_mhz_io_clock,
  input wire logic two_mhz_clock_out,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic module_request_n,
  input wire logic module_grant_n,
  input wire logic io_read_not_write
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic c8_q;
  logic [1:0] spd;
  logic [3:0] n8;
  // Raw pin rises: synchroniser delay is fixed, so the count matches
  wire logic [3:0] inc8 = {3'h0, eight_mhz_io_clock & ~c8_q};
  wire logic [3:0] exp_len = (spd == 2'h0) ? 4'h7 : (spd == 2'h1) ? 4'h6 : 4'h5;
  wire logic dir_ok = (io_read_strobe_n ^ io_write_strobe_n) & (io_read_strobe_n ^ io_read_not_write);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      c8_q <= 1'b0;
      spd <= 2'h0;
      n8 <= 4'h0;
    end else begin
      c8_q <= eight_mhz_io_clock;
      spd <= req_valid ? req_addr[20:19] : spd;
      n8 <= simple_io_select_one_n ? 4'h0 : n8 + inc8;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_module_end;
    module_space_select_n && req_done && !$past(module_grant_n, 3);
  endsequence
  sequence s_sync_start;
    $fell(simple_io_select_one_n) && spd == 2'h3;
  endsequence
  a_tc_with_dack: assert property (terminal_count_out |-> !combo_dma_ack_n)
    else $error("tc without dack");
  a_sio2_needs_sio1: assert property (!simple_io_select_two_n |-> !simple_io_select_one_n)
    else $error("sio2 without sio1");
  a_module_no_strobe: assert property (!module_space_select_n |-> io_read_strobe_n && io_write_strobe_n)
    else $error("strobe in module cycle");
  a_strobe_with_sel: assert property ($fell(simple_io_select_one_n) |-> dir_ok)
    else $error("bad strobe at simple start");
  a_write_drives_bus: assert property (!io_write_strobe_n |-> io_data_bus_oe && !io_read_not_write)
    else $error("write without bus drive");
  a_request_has_sel: assert property (!module_request_n |-> !module_space_select_n)
    else $error("request without module select");
  a_module_end: assert property ($rose(module_request_n) |-> s_module_end)
    else $error("module cycle end wrong");
  a_simple_length: assert property ($rose(simple_io_select_one_n) |-> n8 == exp_len && req_done)
    else $error("simple cycle length wrong");
  a_sync_aligned: assert property (s_sync_start |-> $rose(two_mhz_clock_out))
    else $error("sync cycle not aligned");
endmodule // iobd_monitor

bind iobd_top iobd_monitor #(.PC_HOLD(PC_HOLD)) u_mon (.clk_sys, .rst_n, .req_valid, .req_addr, .req_done,
  .io_data_bus_oe, .module_space_select_n, .combo_dma_ack_n, .terminal_count_out, .simple_io_select_one_n,
  .simple_io_select_two_n, .eight_mhz_io_clock, .two_mhz_clock_out, .io_read_strobe_n, .io_write_strobe_n,
  .module_request_n, .module_grant_n, .io_read_not_write);

/* verif/iobd_partner.sv */
// Peripheral model: free 8 MHz clocks, module handshake, read data.
// Assumes the bench sets read_val and slow_grant before each request.
module iobd_partner (
  input wire logic module_request_n,
  input wire logic io_read_strobe_n,
  input wire logic io_read_not_write,
  input wire logic slow_grant,
  input wire logic [15:0] read_val,
  output logic eight_mhz_io_clock,
  output logic eight_mhz_reference,
  output logic module_grant_n,
  output logic module_latch_strobe_n,
  output logic [15:0] io_data_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    eight_mhz_io_clock = 1'b0;
    eight_mhz_reference = 1'b0;
    module_grant_n = 1'b1;
    module_latch_strobe_n = 1'b1;
    io_data_bus_in = 16'h5a5a;
    // Fractional offset keeps both 8 MHz clock edges off the system clock edges
    #0.3;
    forever #62.5 eight_mhz_io_clock = ~eight_mhz_io_clock;
  end
  // Lagging reference keeps its rises apart from the cycle clock
  always @(eight_mhz_io_clock) eight_mhz_reference <= #37 eight_mhz_io_clock;
  // Released bus shows the inverse, so stale data never matches
  always @(negedge io_read_strobe_n) io_data_bus_in = read_val;
  always @(posedge io_read_strobe_n) io_data_bus_in = ~io_data_bus_in;
  always @(negedge module_request_n) begin
    #(slow_grant ? 902 : 150);
    if (io_read_not_write) io_data_bus_in = read_val;
    #60 module_latch_strobe_n = 1'b0;
    #100 module_latch_strobe_n = 1'b1;
    module_grant_n = 1'b0;
    @(posedge module_request_n);
    #20 module_grant_n = 1'b1;
    io_data_bus_in = ~io_data_bus_in;
  end
endmodule // iobd_partner

/* verif/test_io_bus_decode_simple_module.sv */
// Self-checking bench for the I/O bus decode block with its peripheral model.
// Assumes the checker is bound to the top; selects are sampled every cycle.
module test_io_bus_decode_simple_module;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, req_valid, req_write, req_done, io_data_bus_oe, slow_grant;
  logic [31:0] req_addr, req_wdata, req_rdata, ra;
  logic [15:0] io_data_bus_in, io_data_bus_out, read_val;
  logic extended_area_select_n, module_space_select_n, combo_chip_select_n, combo_dma_ack_n;
  logic terminal_count_out, card_select_one_n, card_select_two_n, simple_io_select_one_n;
  logic simple_io_select_two_n, extra_decode_select, eight_mhz_io_clock, eight_mhz_reference;
  logic two_mhz_clock_out, io_read_strobe_n, io_write_strobe_n, module_request_n, module_grant_n;
  logic io_read_not_write, module_latch_strobe_n;
  integer seed = 43;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] corner [$] = {32'h0300_0000, 32'h0300_3ffe, 32'h0300_4000, 32'h0300_fffe, 32'h0303_0000,
    32'h0303_4000, 32'h0301_0000, 32'h0301_1ffe, 32'h0301_2000, 32'h0302_a000, 32'h0302_affe, 32'h0302_b000,
    32'h0302_b800, 32'h0302_bffe, 32'h0302_c000, 32'h0304_0000, 32'h0320_0000, 32'h0340_0000, 32'h0800_0000,
    32'h08ff_fffe, 32'h0900_0000, 32'h0fff_fffe, 32'h1000_0000, 32'h0324_3ffe, 32'h0324_4000, 32'h0321_0000};
  // Same order as the block's select vector, active high
  wire logic [8:0] act = ~{simple_io_select_two_n, simple_io_select_one_n, card_select_two_n, card_select_one_n,
    ~terminal_count_out, combo_dma_ack_n, combo_chip_select_n, module_space_select_n, extended_area_select_n};

  iobd_top #(.PC_HOLD(2)) dut_u (.clk_sys, .rst_n, .req_valid, .req_addr, .req_write, .req_wdata, .req_done,
    .req_rdata, .io_data_bus_in, .io_data_bus_out, .io_data_bus_oe, .extended_area_select_n,
    .module_space_select_n, .combo_chip_select_n, .combo_dma_ack_n, .terminal_count_out, .card_select_one_n,
    .card_select_two_n, .simple_io_select_one_n, .simple_io_select_two_n, .extra_decode_select,
    .eight_mhz_io_clock, .eight_mhz_reference, .two_mhz_clock_out, .io_read_strobe_n, .io_write_strobe_n,
    .module_request_n, .module_grant_n, .io_read_not_write, .module_latch_strobe_n);
  iobd_partner u_peer (.module_request_n, .io_read_strobe_n, .io_read_not_write, .slow_grant, .read_val,
    .eight_mhz_io_clock, .eight_mhz_reference, .module_grant_n, .module_latch_strobe_n, .io_data_bus_in);

  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Ceiling well above the longest expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  function automatic logic in_rng(input logic [31:0] a, lo, hi);
    return a >= lo && a < hi;
  endfunction

  function automatic logic [8:0] exp_sel(input logic [31:0] a, input logic x);
    logic n;
    logic s1;
    n = !x || a[15:14] == 2'h0;
    s1 = in_rng(a, 32'h0321_0000, 32'h0340_0000);
    return {s1 && a[18:16] == 3'h4 && n, s1, in_rng(a, 32'h0302_b000, 32'h0302_b800),
      in_rng(a, 32'h0302_b800, 32'h0302_c000), in_rng(a, 32'h0302_a000, 32'h0302_b000),
      in_rng(a, 32'h0301_2000, 32'h0302_b000), in_rng(a, 32'h0301_0000, 32'h0301_2000),
      a[31:24] == 8'h03 && (a[23:16] == 8'h00 || a[23:16] == 8'h03) && n,
      a[31:27] == 5'h01 && (!x || a[26:24] == 3'h0)};
  endfunction

  // Entered just after an edge; returns just after the edge that follows the done edge
  task automatic access(input logic [31:0] a, input logic w, input logic x);
    logic [8:0] seen;
    logic [8:0] exp;
    logic [15:0] wd;
    int n;
    seen = 9'h000;
    wd = 16'h0000;
    n = 0;
    exp = exp_sel(a, x);
    if (extra_decode_select !== x) begin
      extra_decode_select = x;
      repeat (6) @(posedge clk_sys);
      #1;
    end
    read_val = 16'($random(seed));
    slow_grant = 1'($random(seed));
    req_addr = a;
    req_write = w;
    req_wdata = $random(seed);
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    while (req_done !== 1'b1 && n < 4000) begin
      seen |= act;
      if (io_data_bus_oe === 1'b1) wd = io_data_bus_out;
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("done", {31'h0, req_done}, 32'h1);
    check("sel lo", {27'h0, seen[4:0]}, {27'h0, exp[4:0]});
    check("sel hi", {28'h0, seen[8:5]}, {28'h0, exp[8:5]});
    if (exp == 9'h000) begin
      // Done rises at the take edge itself, so it is seen before any wait
      check("quick done", n, 32'h0);
      check("empty read", req_rdata, 32'h0);
    end else if (w) begin
      check("write data", {16'h0, wd}, {16'h0, req_wdata[31:16]});
    end else begin
      check("read data", req_rdata, {16'h0, read_val});
    end
    // One edge between requests so valid never toggles twice in a step
    @(posedge clk_sys);
    #1;
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_addr = 32'h0;
    req_write = 1'b0;
    req_wdata = 32'h0;
    extra_decode_select = 1'b0;
    slow_grant = 1'b0;
    read_val = 16'h0;
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    for (int x = 0; x < 2; x++) begin
      foreach (corner[i]) access(corner[i], i[0] ^ x[0], x[0]);
      // Four speeds, each in one second-select window
      for (int s = 0; s < 8; s++) access({11'h019, s[2:1], 19'h40000}, s[0], x[0]);
    end
    repeat (40) begin
      ra = $random(seed);
      access(corner[ra[20:16] % corner.size()] + {20'h0, ra[11:0]}, ra[30], ra[31]);
    end
    close_out();
  end
endmodule // test_io_bus_decode_simple_module
